// ---- include/sbt_cfg.svh ----
// constants for the sram boundary-scan test access port
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH

// register lengths
`define SBT_IR_LEN        3
`define SBT_BYP_LEN       1
`define SBT_ID_LEN        32
`define SBT_BSR_LEN_X36   70
`define SBT_BSR_LEN_X18   51

// instruction codes
`define SBT_IR_SAMPLEZ0   3'h0
`define SBT_IR_IDCODE     3'h1
`define SBT_IR_SAMPLEZ1   3'h2
`define SBT_IR_SAMPLE     3'h4
`define SBT_IR_BYPASS     3'h3
`define SBT_IR_CAPTURE    3'h1
`define SBT_IR_RESET      3'h1

// identity word layout
`define SBT_ID_REV_LSB    28
`define SBT_ID_CFG_LSB    18
`define SBT_ID_VND_LSB    12
`define SBT_ID_MFR_LSB    1
`define SBT_ID_START      1'h1

// unconnected pin cells and their fixed captures
`define SBT_NC0_X36       17
`define SBT_NC1_X36       16
`define SBT_NC0_X18       39
`define SBT_NC1_X18       40
`define SBT_NC0_VAL       1'h0
`define SBT_NC1_VAL       1'h1

// pin idle levels: tck low, tms and tdi high
`define SBT_PIN_IDLE      3'h3
`define SBT_TLR_ONES      3'h5

`endif

// ---- include/sbt_pkg.sv ----
// types shared by the test access port
`include "sbt_cfg.svh"
`default_nettype none
package sbt_pkg;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE  = 4'h1, SEL_DR    = 4'h2, CAP_DR    = 4'h3,
    SHIFT_DR  = 4'h4, EXIT1_DR  = 4'h5, PAUSE_DR  = 4'h6, EXIT2_DR  = 4'h7,
    UPD_DR    = 4'h8, SEL_IR    = 4'h9, CAP_IR    = 4'hA, SHIFT_IR  = 4'hB,
    EXIT1_IR  = 4'hC, PAUSE_IR  = 4'hD, EXIT2_IR  = 4'hE, UPD_IR    = 4'hF
  } sbt_tap_state_t;

  typedef enum logic [1:0] {
    OP_SAMPLEZ = 2'h0,
    OP_IDCODE  = 2'h1,
    OP_SAMPLE  = 2'h2,
    OP_BYPASS  = 2'h3
  } sbt_op_t;

  function automatic sbt_op_t sbt_decode(input logic [`SBT_IR_LEN-1:0] code);
    case (code)
      `SBT_IR_SAMPLEZ0: sbt_decode = OP_SAMPLEZ;
      `SBT_IR_SAMPLEZ1: sbt_decode = OP_SAMPLEZ;
      `SBT_IR_IDCODE:   sbt_decode = OP_IDCODE;
      `SBT_IR_SAMPLE:   sbt_decode = OP_SAMPLE;
      default:          sbt_decode = OP_BYPASS;
    endcase
  endfunction

endpackage
`default_nettype wire

// ---- design/sbt_tap_fsm.sv ----
// sixteen-state test access port controller
`include "sbt_cfg.svh"
`default_nettype none
module sbt_tap_fsm (
  // system
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  // sampled test pins
  input  wire logic                    tck_rise,
  input  wire logic                    tms_s,
  // controller state
  output sbt_pkg::sbt_tap_state_t      state
);

  sbt_pkg::sbt_tap_state_t next_state;

  // srst stands in for the power-up reset; there is no reset pin
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= sbt_pkg::TAP_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  always_comb begin
    case (state)
      sbt_pkg::TAP_RESET: next_state = tms_s ? sbt_pkg::TAP_RESET : sbt_pkg::TAP_IDLE;
      sbt_pkg::TAP_IDLE:  next_state = tms_s ? sbt_pkg::SEL_DR    : sbt_pkg::TAP_IDLE;
      sbt_pkg::SEL_DR:    next_state = tms_s ? sbt_pkg::SEL_IR    : sbt_pkg::CAP_DR;
      sbt_pkg::CAP_DR:    next_state = tms_s ? sbt_pkg::EXIT1_DR  : sbt_pkg::SHIFT_DR;
      sbt_pkg::SHIFT_DR:  next_state = tms_s ? sbt_pkg::EXIT1_DR  : sbt_pkg::SHIFT_DR;
      sbt_pkg::EXIT1_DR:  next_state = tms_s ? sbt_pkg::UPD_DR    : sbt_pkg::PAUSE_DR;
      sbt_pkg::PAUSE_DR:  next_state = tms_s ? sbt_pkg::EXIT2_DR  : sbt_pkg::PAUSE_DR;
      sbt_pkg::EXIT2_DR:  next_state = tms_s ? sbt_pkg::UPD_DR    : sbt_pkg::SHIFT_DR;
      sbt_pkg::UPD_DR:    next_state = tms_s ? sbt_pkg::SEL_DR    : sbt_pkg::TAP_IDLE;
      sbt_pkg::SEL_IR:    next_state = tms_s ? sbt_pkg::TAP_RESET : sbt_pkg::CAP_IR;
      sbt_pkg::CAP_IR:    next_state = tms_s ? sbt_pkg::EXIT1_IR  : sbt_pkg::SHIFT_IR;
      sbt_pkg::SHIFT_IR:  next_state = tms_s ? sbt_pkg::EXIT1_IR  : sbt_pkg::SHIFT_IR;
      sbt_pkg::EXIT1_IR:  next_state = tms_s ? sbt_pkg::UPD_IR    : sbt_pkg::PAUSE_IR;
      sbt_pkg::PAUSE_IR:  next_state = tms_s ? sbt_pkg::EXIT2_IR  : sbt_pkg::PAUSE_IR;
      sbt_pkg::EXIT2_IR:  next_state = tms_s ? sbt_pkg::UPD_IR    : sbt_pkg::SHIFT_IR;
      sbt_pkg::UPD_IR:    next_state = tms_s ? sbt_pkg::SEL_DR    : sbt_pkg::TAP_IDLE;
      default:            next_state = sbt_pkg::TAP_RESET;
    endcase
  end

endmodule
`default_nettype wire

// ---- design/sbt_tap.sv ----
// boundary-scan test access port of the pipelined sram
`include "sbt_cfg.svh"
`default_nettype none
module sbt_tap #(
  parameter bit          WIDE_X36   = 1'b1,
  parameter logic [3:0]  REV_NUM    = 4'h5,     // arbitrary value
  parameter logic [9:0]  PART_CFG   = 10'h2A5,  // arbitrary value
  parameter logic [5:0]  VENDOR_DEF = 6'h2C,    // arbitrary value
  parameter logic [10:0] MFR_CODE   = 11'h155,  // arbitrary value
  localparam int         BSR_LEN    = WIDE_X36 ? `SBT_BSR_LEN_X36 : `SBT_BSR_LEN_X18
) (
  // system
  input  wire logic               clk_sys,
  input  wire logic               srst,
  // test port pins
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo_out,
  output logic                    tdo_oe,
  // sram pin levels seen by the scan cells
  input  wire logic [BSR_LEN-1:0] scan_pins_in,
  // data pin float request to the sram pads
  output logic                    dq_float
);

  localparam int NC0 = WIDE_X36 ? `SBT_NC0_X36 : `SBT_NC0_X18;
  localparam int NC1 = WIDE_X36 ? `SBT_NC1_X36 : `SBT_NC1_X18;

  // pin synchronisers; tck/tms/tdi packed as {tck, tms, tdi}
  logic [2:0]                 pin_m;
  logic [2:0]                 pin_s;
  logic                       tck_d;
  logic [BSR_LEN-1:0]         scan_m;
  logic [BSR_LEN-1:0]         scan_s;

  // scan registers
  logic [`SBT_IR_LEN-1:0]     ir_shift;
  logic [`SBT_IR_LEN-1:0]     ir_active;
  logic                       bypass_bit;
  logic [`SBT_ID_LEN-1:0]     id_shift;
  logic [BSR_LEN-1:0]         bsr;

  // decoded strobes and selections
  sbt_pkg::sbt_tap_state_t    state;
  sbt_pkg::sbt_op_t           op;
  sbt_pkg::sbt_op_t           upd_op;
  logic                       tck_s;
  logic                       tms_s;
  logic                       tdi_s;
  logic                       tck_rise;
  logic                       tck_fall;
  logic                       in_tlr;
  logic                       cap_ir;
  logic                       sh_ir;
  logic                       upd_ir;
  logic                       cap_dr;
  logic                       sh_dr;
  logic                       shifting;
  logic                       bsr_sel;
  logic                       tdo_next;
  logic [`SBT_ID_LEN-1:0]     id_word;
  logic [BSR_LEN-1:0]         cap_val;
  logic                       instr_code_msb;
  logic                       instr_code_lsb;

  // idle levels match the pads' pull-ups, so an open tms or tdi reads high
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_m <= `SBT_PIN_IDLE;
      pin_s <= `SBT_PIN_IDLE;
      tck_d <= 1'b0;
    end else begin
      pin_m <= {tck, tms, tdi};
      pin_s <= pin_m;
      tck_d <= pin_s[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scan_m <= '0;
      scan_s <= '0;
    end else begin
      scan_m <= scan_pins_in;
      scan_s <= scan_m;
    end
  end

  assign tck_s    = pin_s[2];
  assign tms_s    = pin_s[1];
  assign tdi_s    = pin_s[0];
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  sbt_tap_fsm u_fsm (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .tck_rise (tck_rise),
    .tms_s    (tms_s),
    .state    (state)
  );

  // instruction falls back to idcode while in reset, not only on the next rise
  assign in_tlr   = (state == sbt_pkg::TAP_RESET);
  assign cap_ir   = tck_rise && (state == sbt_pkg::CAP_IR);
  assign sh_ir    = tck_rise && (state == sbt_pkg::SHIFT_IR);
  assign upd_ir   = tck_rise && (state == sbt_pkg::UPD_IR);
  assign cap_dr   = tck_rise && (state == sbt_pkg::CAP_DR);
  assign sh_dr    = tck_rise && (state == sbt_pkg::SHIFT_DR);
  assign shifting = (state == sbt_pkg::SHIFT_IR) || (state == sbt_pkg::SHIFT_DR);

  assign op             = sbt_pkg::sbt_decode(ir_active);
  assign upd_op         = sbt_pkg::sbt_decode(ir_shift);
  assign instr_code_msb = ir_active[`SBT_IR_LEN-1];
  assign instr_code_lsb = ir_active[0];
  assign bsr_sel        = (op == sbt_pkg::OP_SAMPLE) || (op == sbt_pkg::OP_SAMPLEZ);

  // identity word fields, msb first
  assign id_word = {REV_NUM, PART_CFG, VENDOR_DEF, MFR_CODE, `SBT_ID_START};

  // cells of unconnected pin positions capture constants
  genvar gi;
  for (gi = 0; gi < BSR_LEN; gi++) begin : g_cap
    if (gi == NC0) begin : g_nc0
      assign cap_val[gi] = `SBT_NC0_VAL;
    end else if (gi == NC1) begin : g_nc1
      assign cap_val[gi] = `SBT_NC1_VAL;
    end else begin : g_pin
      assign cap_val[gi] = scan_s[gi];
    end
  end

  // instruction register; idcode after controller reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ir_shift  <= `SBT_IR_CAPTURE;
      ir_active <= `SBT_IR_RESET;
    end else begin
      if (cap_ir) begin
        ir_shift <= `SBT_IR_CAPTURE;
      end else if (sh_ir) begin
        ir_shift <= {tdi_s, ir_shift[`SBT_IR_LEN-1:1]};
      end
      if (in_tlr) begin
        ir_active <= `SBT_IR_RESET;
      end else if (upd_ir) begin
        ir_active <= ir_shift;
      end
    end
  end

  // bypass bit: no shift outside shift-dr, so it holds the last tdi bit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bypass_bit <= 1'b0;
    end else if ((upd_ir && upd_op == sbt_pkg::OP_BYPASS) || (cap_dr && op == sbt_pkg::OP_BYPASS)) begin
      bypass_bit <= 1'b0;
    end else if (sh_dr && op == sbt_pkg::OP_BYPASS) begin
      bypass_bit <= tdi_s;
    end
  end

  // identity shifter; tdi enters the top stage, bit 0 leaves first
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      id_shift <= '0;
    end else if (cap_dr && op == sbt_pkg::OP_IDCODE) begin
      id_shift <= id_word;
    end else if (sh_dr && op == sbt_pkg::OP_IDCODE) begin
      id_shift <= {tdi_s, id_shift[`SBT_ID_LEN-1:1]};
    end
  end

  // pin scan chain: capture and shift only; no update stage exists,
  // so neither the array nor the pins are ever driven from it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bsr <= '0;
    end else if (cap_dr && bsr_sel) begin
      bsr <= cap_val;
    end else if (sh_dr && bsr_sel) begin
      bsr <= {tdi_s, bsr[BSR_LEN-1:1]};
    end
  end

  assign tdo_next = (state == sbt_pkg::SHIFT_IR) ? ir_shift[0] :
                    (op == sbt_pkg::OP_IDCODE)   ? id_shift[0] :
                    (op == sbt_pkg::OP_BYPASS)   ? bypass_bit  : bsr[0];

  // falling edge launch gives the controller half a tck of setup
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tdo_out <= 1'b0;
      tdo_oe  <= 1'b0;
    end else if (tck_fall) begin
      tdo_out <= shifting ? tdo_next : 1'b0;
      tdo_oe  <= shifting;
    end
  end

  // plain sample keeps the data pins driving
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dq_float <= 1'b0;
    end else begin
      dq_float <= (op == sbt_pkg::OP_SAMPLEZ);
    end
  end

  // consecutive tms-high rising edges, for checking only
  logic [2:0] ones_cnt;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ones_cnt <= 3'h0;
    end else if (tck_rise) begin
      ones_cnt <= !tms_s ? 3'h0 : (ones_cnt == `SBT_TLR_ONES) ? ones_cnt : ones_cnt + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence s_id_fall;
    tck_fall && state == sbt_pkg::SHIFT_DR && op == sbt_pkg::OP_IDCODE;
  endsequence

  sequence s_leave_byp;
    sh_dr && tms_s && op == sbt_pkg::OP_BYPASS;
  endsequence

  property p_idcode_tdo;
    s_id_fall |=> (tdo_out == $past(id_shift[0])) && tdo_oe;
  endproperty
  a_idcode_tdo: assert property (p_idcode_tdo)
    else $error("idcode bit not on tdo");

  property p_sample_capture;
    cap_dr && op == sbt_pkg::OP_SAMPLE |=> bsr == $past(cap_val);
  endproperty
  a_sample_capture: assert property (p_sample_capture)
    else $error("sample did not capture pins");

  property p_samplez_codes;
    (ir_active == `SBT_IR_SAMPLEZ0) || (ir_active == `SBT_IR_SAMPLEZ1) |-> op == sbt_pkg::OP_SAMPLEZ;
  endproperty
  a_samplez_codes: assert property (p_samplez_codes)
    else $error("float-sample code misdecoded");

  property p_bypass_codes;
    (ir_active == `SBT_IR_BYPASS) || (instr_code_msb && (ir_active != `SBT_IR_SAMPLE)) |-> op == sbt_pkg::OP_BYPASS;
  endproperty
  a_bypass_codes: assert property (p_bypass_codes)
    else $error("bypass code misdecoded");

  property p_float_on;
    op == sbt_pkg::OP_SAMPLEZ ##1 op == sbt_pkg::OP_SAMPLEZ |-> dq_float;
  endproperty
  a_float_on: assert property (p_float_on)
    else $error("data pins not floated");

  property p_float_off;
    op == sbt_pkg::OP_SAMPLE |=> !dq_float;
  endproperty
  a_float_off: assert property (p_float_off)
    else $error("plain sample floated data pins");

  property p_id_tdi_first;
    sh_dr && op == sbt_pkg::OP_IDCODE |=> id_shift[`SBT_ID_LEN-1] == $past(tdi_s);
  endproperty
  a_id_tdi_first: assert property (p_id_tdi_first)
    else $error("tdi not in first identity stage");

  property p_bypass_clear;
    upd_ir && upd_op == sbt_pkg::OP_BYPASS |=> !bypass_bit && op == sbt_pkg::OP_BYPASS;
  endproperty
  a_bypass_clear: assert property (p_bypass_clear)
    else $error("bypass bit not cleared");

  property p_bypass_keep;
    s_leave_byp |=> (bypass_bit == $past(tdi_s)) ##1 $stable(bypass_bit);
  endproperty
  a_bypass_keep: assert property (p_bypass_keep)
    else $error("bypass bit lost on exit");

  property p_id_layout;
    cap_dr && op == sbt_pkg::OP_IDCODE |=> id_shift[0] == `SBT_ID_START &&
      id_shift[`SBT_ID_VND_LSB-1:`SBT_ID_MFR_LSB] == MFR_CODE &&
      id_shift[`SBT_ID_CFG_LSB-1:`SBT_ID_VND_LSB] == VENDOR_DEF &&
      id_shift[`SBT_ID_REV_LSB-1:`SBT_ID_CFG_LSB] == PART_CFG &&
      id_shift[`SBT_ID_LEN-1:`SBT_ID_REV_LSB] == REV_NUM;
  endproperty
  a_id_layout: assert property (p_id_layout)
    else $error("identity word layout wrong");

  property p_nc_cells;
    cap_dr && bsr_sel |=> bsr[NC0] == `SBT_NC0_VAL && bsr[NC1] == `SBT_NC1_VAL;
  endproperty
  a_nc_cells: assert property (p_nc_cells)
    else $error("unconnected cell capture wrong");

  property p_tlr_ones;
    ones_cnt == `SBT_TLR_ONES |-> state == sbt_pkg::TAP_RESET ##1 ir_active == `SBT_IR_RESET && op == sbt_pkg::OP_IDCODE;
  endproperty
  a_tlr_ones: assert property (p_tlr_ones)
    else $error("five tms highs did not reset");

  property p_tdo_quiet;
    tck_fall && !shifting |=> !tdo_oe && !tdo_out;
  endproperty
  a_tdo_quiet: assert property (p_tdo_quiet)
    else $error("tdo driven outside shift");

  property p_tdo_on_fall;
    !tck_fall |=> $stable(tdo_out) && $stable(tdo_oe);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("tdo moved off a falling edge");

endmodule
`default_nettype wire

// ---- tb/sbt_host.sv ----
// jtag test controller model driving the link pins
`default_nettype none
module sbt_host (
  // system
  input  wire logic clk_sys,
  // link pins
  output var logic  tck,
  output var logic  tms,
  output var logic  tdi,
  input  wire logic tdo_out,
  input  wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic tdo_last = 1'h0;
  wire  tdo_pin;

  // no pull on tdo: a released pin shows the inverse of its last level
  assign tdo_pin = tdo_oe ? tdo_out : ~tdo_last;
  always @(posedge clk_sys) if (tdo_oe) tdo_last <= tdo_out;

  initial begin
    tck = 1'h0;
    tms = 1'h1;  // idle high, as pulled-up pins read
    tdi = 1'h1;
  end

  // one tck period: 4 clk_sys low, 4 high
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk_sys);
    #2;
    tck = 1'h0;
    tms = m;  // set up long before the rise
    tdi = d;
    repeat (4) @(posedge clk_sys);
    #2;
    q   = tdo_pin;  // taken at the rising edge
    tck = 1'h1;
    repeat (3) @(posedge clk_sys);
  endtask

  // tck stands low between frames
  task automatic park();
    @(posedge clk_sys);
    #2;
    tck = 1'h0;
  endtask

  task automatic to_idle();
    logic q;
    for (int i = 0; i < 5; i++) step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    park();
  endtask

  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic q;
    step(1'h1, 1'h1, q);
    step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    step(1'h0, 1'h1, q);
    for (int i = 0; i < 3; i++) begin
      step(logic'(i == 2), code[i], q);
      cap[i] = q;
    end
    step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    park();
  endtask

  // dr scan with one pause in the middle, bits lsb first
  task automatic shift_dr(input int n, input logic [127:0] din, input int pause_at,
                          output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    step(1'h0, 1'h1, q);
    for (int i = 0; i < n; i++) begin
      step(logic'(i == n - 1 || i == pause_at - 1), din[i], q);
      dout[i] = q;
      if (i == pause_at - 1 && i != n - 1) begin
        step(1'h0, 1'h1, q);
        step(1'h1, 1'h1, q);
        step(1'h0, 1'h1, q);
      end
    end
    step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    park();
  endtask
endmodule
`default_nettype wire

// ---- tb/sbt_tap_tb.sv ----
// self-checking bench for the sram test access port
`include "sbt_cfg.svh"
`default_nettype none
module sbt_tap_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int          NBITS   = 110;
  localparam int          BSR_LEN = `SBT_BSR_LEN_X36;
  localparam logic [3:0]  ID_REV  = 4'h9;    // arbitrary value
  localparam logic [9:0]  ID_CFG  = 10'h1b3; // arbitrary value
  localparam logic [5:0]  ID_VND  = 6'h15;   // arbitrary value
  localparam logic [10:0] ID_MFR  = 11'h2d9; // arbitrary value
  localparam logic [31:0] ID_WORD = {ID_REV, ID_CFG, ID_VND, ID_MFR, 1'h1};

  logic               clk_sys      = 1'h0;
  logic               srst         = 1'h1;
  logic [BSR_LEN-1:0] scan_pins_in = '0;
  wire logic          tck;
  wire logic          tms;
  wire logic          tdi;
  wire logic          tdo_out;
  wire logic          tdo_oe;
  wire logic          dq_float;
  wire logic          tdo18_out;
  wire logic          tdo18_oe;
  wire logic          dq18_float;
  logic [127:0]       dout18;
  int                 error_cnt    = 0;
  int                 n_compared   = 0;
  int                 seed         = 32'hacae_ace2;
  logic [2:0]         code;
  logic [2:0]         cap;

  always #10 clk_sys = ~clk_sys;

  sbt_tap #(
    .WIDE_X36   (1'h1),
    .REV_NUM    (ID_REV),
    .PART_CFG   (ID_CFG),
    .VENDOR_DEF (ID_VND),
    .MFR_CODE   (ID_MFR)
  ) sbt_tap_inst (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .tck          (tck),
    .tms          (tms),
    .tdi          (tdi),
    .tdo_out      (tdo_out),
    .tdo_oe       (tdo_oe),
    .scan_pins_in (scan_pins_in),
    .dq_float     (dq_float)
  );

  // narrow option on the same link pins, so both chain lengths are scanned
  sbt_tap #(
    .WIDE_X36   (1'h0),
    .REV_NUM    (ID_REV),
    .PART_CFG   (ID_CFG),
    .VENDOR_DEF (ID_VND),
    .MFR_CODE   (ID_MFR)
  ) sbt_tap_x18_inst (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .tck          (tck),
    .tms          (tms),
    .tdi          (tdi),
    .tdo_out      (tdo18_out),
    .tdo_oe       (tdo18_oe),
    .scan_pins_in (scan_pins_in[`SBT_BSR_LEN_X18-1:0]),
    .dq_float     (dq18_float)
  );

  // narrow tdo taken at each host tck rise while driven; newest bit on top
  always @(posedge tck) begin
    if (tdo18_oe) begin
      dout18 <= {tdo18_out, dout18[127:1]};
    end
  end

  sbt_host sbt_host_inst (
    .clk_sys (clk_sys),
    .tck     (tck),
    .tms     (tms),
    .tdi     (tdi),
    .tdo_out (tdo_out),
    .tdo_oe  (tdo_oe)
  );

  // what tdo must show: captured path, then tdi delayed by the path length
  function automatic logic [127:0] exp_dr(input logic [2:0] c, input logic [BSR_LEN-1:0] pins,
                                          input logic [127:0] din, input bit x36);
    logic [127:0] e;
    int           len;
    e = '0;
    case (c)
      3'h1: begin
        e[31:0] = ID_WORD;
        len = 32;
      end
      3'h0, 3'h2, 3'h4: begin
        len = x36 ? `SBT_BSR_LEN_X36 : `SBT_BSR_LEN_X18;
        for (int k = 0; k < len; k++) e[k] = pins[k];
        e[x36 ? `SBT_NC0_X36 : `SBT_NC0_X18] = 1'h0;
        e[x36 ? `SBT_NC1_X36 : `SBT_NC1_X18] = 1'h1;
      end
      default: len = 1;
    endcase
    for (int k = len; k < 128; k++) e[k] = din[k - len];
    return e;
  endfunction

  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic scan(input logic [2:0] c);
    logic [127:0] din;
    logic [127:0] dout;
    logic [127:0] e;
    int           pa;
    @(posedge clk_sys);
    #2;
    din = {$random(seed), $random(seed), $random(seed), $random(seed)};
    scan_pins_in = din[BSR_LEN-1:0];
    din = {$random(seed), $random(seed), $random(seed), $random(seed)};
    pa = int'($unsigned($random(seed)) % (NBITS - 1)) + 1;
    sbt_host_inst.shift_dr(NBITS, din, pa, dout);
    e = exp_dr(c, scan_pins_in, din, 1'h1);
    chk(dout[NBITS-1:0] === e[NBITS-1:0], "scan path contents");
    e = exp_dr(c, scan_pins_in, din, 1'h0);
    chk(dout18[127:128-NBITS] === e[NBITS-1:0], "narrow scan path contents");
    chk(tdo_oe === 1'h0 && tdo_out === 1'h0, "tdo not released");
    chk(tdo18_oe === 1'h0 && tdo18_out === 1'h0, "narrow tdo not released");
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    #2;
    srst = 1'h0;
    chk(dq_float === 1'h0 && tdo_oe === 1'h0 && dq18_float === 1'h0 && tdo18_oe === 1'h0, "reset levels");
    sbt_host_inst.to_idle();
    scan(3'h1);
    // every code once, then a few random ones back to back
    for (int i = 0; i < 14; i++) begin
      code = (i < 8) ? 3'(i) : 3'($random(seed));
      sbt_host_inst.load_ir(code, cap);
      chk(cap === 3'h1, "ir capture");
      chk({dq_float, dq18_float} === {2{logic'(code == 3'h0 || code == 3'h2)}}, "float level");
      scan(code);
    end
    // tms walk to reset must end a float instruction
    sbt_host_inst.load_ir(3'h2, cap);
    sbt_host_inst.to_idle();
    chk(dq_float === 1'h0 && dq18_float === 1'h0, "float after tms reset");
    scan(3'h1);
    // power-up reset in mid-run
    sbt_host_inst.load_ir(3'h0, cap);
    @(posedge clk_sys);
    #2;
    srst = 1'h1;
    repeat (2) @(posedge clk_sys);
    #2;
    srst = 1'h0;
    chk(dq_float === 1'h0 && dq18_float === 1'h0, "float after reset");
    sbt_host_inst.to_idle();
    scan(3'h1);
    test_done();
  end

  // about 17.4k clk_sys expected; hang guard well beyond that
  initial begin
    #1_000_000;
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
